//--- logic/prc_pkg.sv
package prc_pkg;
  // Register indices (byte offsets are index * 4, so all are multiples of four)
  localparam logic [3:0] IDX_STATUS  = 4'h0;
  localparam logic [3:0] IDX_POWER   = 4'h2;
  localparam logic [3:0] IDX_RDIV_HI = 4'h3;
  localparam logic [3:0] IDX_RDIV_LO = 4'h4;
  localparam logic [3:0] IDX_LOCKCFG = 4'h7;
  localparam logic [3:0] IDX_REFCFG  = 4'h8;
  localparam logic [3:0] IDX_PUMP    = 4'h9;
  localparam logic [3:0] IDX_PUMPFN  = 4'ha;
  localparam logic [3:0] IDX_STATMSK = 4'hb;
  // Status bit positions
  localparam int ST_UNLOCK = 0;
  localparam int ST_LOCK   = 1;
  localparam int ST_AMPHI  = 2;
  localparam int ST_AMPLO  = 3;
  localparam int ST_THI    = 4;
  localparam int ST_TLO    = 5;
  // Lock config: enable bit 4, window [1:0]
  localparam int LK_EN = 4;
  // Pump register: count [5:4], current code [3:0]
  localparam int PF_WIDE = 0;
  localparam int PF_RST  = 1;
  localparam int PF_DN   = 2;
  localparam int PF_UP   = 3;
  localparam int PF_MID  = 4;
  localparam int PF_INV  = 5;
  localparam int PF_CLO  = 6;
  localparam int PF_CHI  = 7;
  localparam int PW_REFO = 1;
  localparam int RC_BST  = 2;
  // Reset values
  localparam logic [9:0] RDIV_RST   = 10'h001;
  localparam logic [7:0] PUMPFN_RST = 8'h02;
  localparam logic [3:0] CP_MAX     = 4'hb;
  // Timing: lock windows in ns, clock period in ns
  localparam int CLK_NS = 100;
  localparam int WIN0_NS = 3;
  localparam int WIN1_NS = 10;
  localparam int WIN2_NS = 30;
  localparam int WIN3_NS = 90;
  localparam logic [11:0] CNT0 = 12'd32;
  localparam logic [11:0] CNT1 = 12'd128;
  localparam logic [11:0] CNT2 = 12'd512;
  localparam logic [11:0] CNT3 = 12'd2048;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic up;
    logic down;
  } prc_pulse_t;
endpackage : prc_pkg

//--- logic/prc_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Reference divider is 10 bits, ratio 1 to 1023.
// - Divide value split over byte registers 3 and 4, used directly.
// - Phase detector gives UP or DOWN pulses sized by phase difference.
// - Detector hold-reset bit blocks detector UP and DOWN pulses; force bits still drive.
// - Lock indicator runs only when enabled; flags in status and pin.
// - Window codes 0..3 choose 3, 10, 30, 90 ns coincidence.
// - Locked only after the chosen count of successive in-window compares.
// - Count codes 0..3 choose 32, 128, 512, 2048 compares.
// - Out-of-window compare sets out-of-lock and clears locked at once.
// - Out-of-lock clears on first in-window compare.
// - Pump current code 0..11 valid, 12..15 invalid.
// - Polarity invert swaps UP and DOWN sense.
// - Upper clamp enabled and high: set flag, block sourcing.
// - Lower clamp enabled and low: set flag, block sinking.
// - Force bits drive constant current; all zero for lock.
// - Pulse extend lengthens detector reset delay, widening pulses.
// - Power bit disables reference output buffer.
// - Status pin is masked OR of the six flags.
module prc_top #(
  parameter int RDIV_W = 10
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ref_in,
  input  wire logic        i_fb_div,
  input  wire logic        i_cmp_high,
  input  wire logic        i_cmp_low,
  input  wire logic        i_amp_high,
  input  wire logic        i_amp_low,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             o_ref_div,
  output logic             o_pump_up,
  output logic             o_pump_down,
  output logic [3:0]       o_pump_current_code,
  output logic             o_pump_midrail_bias,
  output logic             o_pump_pulse_extend,
  output logic             o_ref_out_powerdown,
  output logic [1:0]       o_ref_lowpass_select,
  output logic             o_ref_gain_boost,
  output logic             o_stat
);

  // Reset release
  logic       rst_s1;
  logic       rst_n;
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b) {rst_n, rst_s1} <= 2'b00;
    else          {rst_n, rst_s1} <= {rst_s1, 1'b1};
  end

  // Pin synchronisers, first stage read only by second
  logic [5:0] sync1;
  logic [5:0] sync2;
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n) {sync2, sync1} <= 12'h000;
    else        {sync2, sync1} <= {sync1, i_amp_low, i_amp_high, i_cmp_low, i_cmp_high,
                                   i_fb_div, i_ref_in};
  end
  wire ref_s  = sync2[0];
  wire fb_s   = sync2[1];
  wire chi_s  = sync2[2];
  wire clo_s  = sync2[3];
  wire amph_s = sync2[4];
  wire ampl_s = sync2[5];

  // Register storage
  logic [RDIV_W-1:0] rdiv;
  logic [7:0]        power;
  logic [7:0]        lockcfg;
  logic [7:0]        refcfg;
  logic [7:0]        pump;
  logic [7:0]        pumpfn;
  logic [5:0]        statmsk;
  logic [5:0]        status;

  // AXI write path: address and data latch in either order
  logic        aw_hold;
  logic        w_hold;
  logic [3:0]  aw_idx;
  logic [7:0]  w_byte;
  logic        w_lane;
  wire         aw_take = s_axi_awvalid & s_axi_awready;
  wire         w_take  = s_axi_wvalid & s_axi_wready;
  wire         wr_go   = aw_hold & w_hold & !s_axi_bvalid;
  wire         wr_ok   = (aw_idx == prc_pkg::IDX_POWER) | (aw_idx == prc_pkg::IDX_RDIV_HI) |
                         (aw_idx == prc_pkg::IDX_RDIV_LO) | (aw_idx == prc_pkg::IDX_LOCKCFG) |
                         (aw_idx == prc_pkg::IDX_REFCFG) | (aw_idx == prc_pkg::IDX_PUMP) |
                         (aw_idx == prc_pkg::IDX_PUMPFN) | (aw_idx == prc_pkg::IDX_STATMSK);
  wire         wr_en   = wr_go & wr_ok & w_lane;

  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_idx <= 4'h0;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= prc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_hold & !aw_take & !s_axi_awready;
      s_axi_wready <= !w_hold & !w_take & !s_axi_wready;
      if (aw_take)
      begin
        aw_hold <= 1'b1;
        aw_idx <= s_axi_awaddr[5:2];
      end
      if (w_take)
      begin
        w_hold <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (wr_go)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR; // Unmapped refused
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; divider value stored as the ratio itself
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdiv <= prc_pkg::RDIV_RST;
      power <= 8'h00;
      lockcfg <= 8'h00;
      refcfg <= 8'h00;
      pump <= 8'h00;
      pumpfn <= prc_pkg::PUMPFN_RST;
      statmsk <= 6'h00;
    end
    else if (wr_en)
    begin
      case (aw_idx)
        prc_pkg::IDX_RDIV_HI: rdiv[RDIV_W-1:8] <= w_byte[RDIV_W-9:0];
        prc_pkg::IDX_RDIV_LO: rdiv[7:0] <= w_byte;
        prc_pkg::IDX_POWER:   power <= w_byte;
        prc_pkg::IDX_LOCKCFG: lockcfg <= w_byte;
        prc_pkg::IDX_REFCFG:  refcfg <= w_byte;
        prc_pkg::IDX_PUMP:    pump <= w_byte;
        prc_pkg::IDX_PUMPFN:  pumpfn <= w_byte;
        prc_pkg::IDX_STATMSK: statmsk <= w_byte[5:0];
        default:              power <= power;
      endcase
    end
  end

  // Read mux
  logic [7:0] rd_val;
  always_comb
  begin
    case (s_axi_araddr[5:2])
      prc_pkg::IDX_STATUS:  rd_val = {2'b00, status};
      prc_pkg::IDX_POWER:   rd_val = power;
      prc_pkg::IDX_RDIV_HI: rd_val = {6'h00, rdiv[RDIV_W-1:8]};
      prc_pkg::IDX_RDIV_LO: rd_val = rdiv[7:0];
      prc_pkg::IDX_LOCKCFG: rd_val = lockcfg;
      prc_pkg::IDX_REFCFG:  rd_val = refcfg;
      prc_pkg::IDX_PUMP:    rd_val = pump;
      prc_pkg::IDX_PUMPFN:  rd_val = pumpfn;
      prc_pkg::IDX_STATMSK: rd_val = {2'b00, statmsk};
      default:              rd_val = 8'h00;
    endcase
  end
  wire rd_hit = (s_axi_araddr[5:2] <= prc_pkg::IDX_STATMSK) &
                (s_axi_araddr[5:2] != 4'h1) & (s_axi_araddr[5:2] != 4'h5) &
                (s_axi_araddr[5:2] != 4'h6);

  // AXI read path, one cycle ready pulse then data
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= prc_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & !s_axi_arready & !s_axi_rvalid;
      if (s_axi_arvalid & s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_hit ? prc_pkg::RESP_OKAY : prc_pkg::RESP_SLVERR;
      end
      else if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Reference divider; ratio 0 treated as 1
  logic [RDIV_W-1:0] rcnt;
  logic              ref_d;
  wire               ref_rise = ref_s & !ref_d;
  wire               rwrap = (rcnt >= rdiv - 10'd1) | (rdiv == 10'd0);
  wire               div_one = (rdiv <= 10'd1);
  logic              rdiv_pulse;
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_d <= 1'b0;
      rcnt <= '0;
      rdiv_pulse <= 1'b0;
      o_ref_div <= 1'b0;
    end
    else
    begin
      ref_d <= ref_s;
      rdiv_pulse <= ref_rise & rwrap;
      if (ref_rise)
        rcnt <= rwrap ? '0 : rcnt + 10'd1;
      // Ratio 1 has no count to split, so the output follows the reference
      if (div_one)
        o_ref_div <= ref_s;
      else if (ref_rise)
        o_ref_div <= (rcnt < (rdiv >> 1)) & !rwrap;
    end
  end

  // Feedback edge
  logic fb_d;
  wire  fb_rise = fb_s & !fb_d;

  // Phase detector state; hold-reset and both-high clear it
  logic       pd_up;
  logic       pd_dn;
  logic [1:0] ext_cnt;
  logic [7:0] diff_cnt;
  wire        pd_hold = pumpfn[prc_pkg::PF_RST];
  wire        both = (pd_up | rdiv_pulse) & (pd_dn | fb_rise);
  wire        cmp_done = both & (ext_cnt == 2'd0);
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fb_d <= 1'b0;
      pd_up <= 1'b0;
      pd_dn <= 1'b0;
      ext_cnt <= 2'd0;
      diff_cnt <= 8'h00;
    end
    else
    begin
      fb_d <= fb_s;
      if (pd_hold)
      begin
        pd_up <= 1'b0;
        pd_dn <= 1'b0;
        ext_cnt <= 2'd0;
        diff_cnt <= 8'h00;
      end
      else if (ext_cnt != 2'd0)
      begin
        // Extension ends by clearing both, else the pair would re-arm forever
        ext_cnt <= ext_cnt - 2'd1;
        if (ext_cnt == 2'd1)
        begin
          pd_up <= 1'b0;
          pd_dn <= 1'b0;
        end
      end
      else if (both)
      begin
        // Extended reset delay holds both briefly, widening pulses
        ext_cnt <= pumpfn[prc_pkg::PF_WIDE] ? 2'd2 : 2'd0;
        pd_up <= pumpfn[prc_pkg::PF_WIDE];
        pd_dn <= pumpfn[prc_pkg::PF_WIDE];
        diff_cnt <= 8'h00;
      end
      else
      begin
        pd_up <= pd_up | rdiv_pulse;
        pd_dn <= pd_dn | fb_rise;
        if ((pd_up | pd_dn) & (diff_cnt != 8'hff))
          diff_cnt <= diff_cnt + 8'h01;
      end
    end
  end

  // Window limit in clock cycles, at least one; count select table
  function automatic logic [7:0] win_cycles(input logic [1:0] sel);
    int ns;
    ns = (sel == 2'd0) ? prc_pkg::WIN0_NS : (sel == 2'd1) ? prc_pkg::WIN1_NS :
         (sel == 2'd2) ? prc_pkg::WIN2_NS : prc_pkg::WIN3_NS;
    return (ns < prc_pkg::CLK_NS) ? 8'd1 : 8'((ns + prc_pkg::CLK_NS - 1) / prc_pkg::CLK_NS);
  endfunction : win_cycles
  function automatic logic [11:0] req_count(input logic [1:0] sel);
    return (sel == 2'd0) ? prc_pkg::CNT0 : (sel == 2'd1) ? prc_pkg::CNT1 :
           (sel == 2'd2) ? prc_pkg::CNT2 : prc_pkg::CNT3;
  endfunction : req_count

  // Lock indicator; difference counted in clocks, coarse at this rate
  wire [11:0] required_coincidence_count = req_count(pump[5:4]);
  wire        coincidence_detect_enable = lockcfg[prc_pkg::LK_EN];
  wire        in_win = diff_cnt < win_cycles(lockcfg[1:0]);
  logic [11:0] co_cnt;
  logic        lock_f;
  logic        unlock_f;
  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      co_cnt <= 12'h000;
      lock_f <= 1'b0;
      unlock_f <= 1'b0;
    end
    else if (!coincidence_detect_enable)
    begin
      co_cnt <= 12'h000;
      lock_f <= 1'b0;
      unlock_f <= 1'b0;
    end
    else if (cmp_done & !pd_hold)
    begin
      if (!in_win)
      begin
        co_cnt <= 12'h000;
        lock_f <= 1'b0;
        unlock_f <= 1'b1;
      end
      else
      begin
        unlock_f <= 1'b0;
        if (co_cnt + 12'h001 >= required_coincidence_count)
          lock_f <= 1'b1;
        else
          co_cnt <= co_cnt + 12'h001;
      end
    end
  end

  // Clamp flags follow live comparator state
  wire upper_clamp_flag = pumpfn[prc_pkg::PF_CHI] & chi_s;
  wire lower_clamp_flag = pumpfn[prc_pkg::PF_CLO] & clo_s;
  wire [5:0] next_status = {lower_clamp_flag, upper_clamp_flag, ampl_s, amph_s,
                            lock_f, unlock_f};

  // Pump drive: invert, force, clamps
  wire src_raw = pumpfn[prc_pkg::PF_INV] ? pd_dn : pd_up;
  wire snk_raw = pumpfn[prc_pkg::PF_INV] ? pd_up : pd_dn;
  wire next_up = (src_raw | pumpfn[prc_pkg::PF_UP]) & !upper_clamp_flag;
  wire next_dn = (snk_raw | pumpfn[prc_pkg::PF_DN]) & !lower_clamp_flag;
  wire [3:0] code = pump[3:0];

  always_ff @(posedge i_ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= 6'h00;
      o_pump_up <= 1'b0;
      o_pump_down <= 1'b0;
      o_pump_current_code <= 4'h0;
      o_pump_midrail_bias <= 1'b0;
      o_pump_pulse_extend <= 1'b0;
      o_ref_out_powerdown <= 1'b0;
      o_ref_lowpass_select <= 2'b00;
      o_ref_gain_boost <= 1'b0;
      o_stat <= 1'b0;
    end
    else
    begin
      status <= next_status;
      o_pump_up <= next_up;
      o_pump_down <= next_dn;
      // Invalid codes clipped to the top valid code
      o_pump_current_code <= (code > prc_pkg::CP_MAX) ? prc_pkg::CP_MAX : code;
      o_pump_midrail_bias <= pumpfn[prc_pkg::PF_MID];
      o_pump_pulse_extend <= pumpfn[prc_pkg::PF_WIDE];
      o_ref_out_powerdown <= power[prc_pkg::PW_REFO];
      o_ref_lowpass_select <= refcfg[1:0];
      o_ref_gain_boost <= refcfg[prc_pkg::RC_BST];
      o_stat <= |(next_status & statmsk);
    end
  end

endmodule : prc_top

//--- bench/prc_chk.sv
`timescale 1ns/10ps
module prc_chk (
  input wire logic        i_ref_clk,
  input wire logic        i_rst_b,
  input wire logic        i_cmp_high,
  input wire logic        i_cmp_low,
  input wire logic        i_amp_high,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        o_pump_up,
  input wire logic        o_pump_down,
  input wire logic [3:0]  o_pump_current_code,
  input wire logic        o_pump_midrail_bias,
  input wire logic        o_stat
);
  logic [3:0] wa;
  logic [7:0] wd, func_sh, code_sh, mask_sh;
  logic [2:0] quiet;
  // Write taken and answered; judging pauses from address take until seven cycles after the answer
  wire taken   = s_axi_awvalid && s_axi_awready;
  wire commit  = s_axi_bvalid && s_axi_bready;
  wire settled = quiet == 3'h7;
  wire [3:0] code_exp = (code_sh[3:0] > prc_pkg::CP_MAX) ? prc_pkg::CP_MAX : code_sh[3:0];

  // Settle counter after any register write
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
    if (!i_rst_b)
      quiet <= 3'h0;
    else
      quiet <= (taken || commit) ? 3'h0 : quiet + {2'h0, !settled};

  // Mirror of written controls, so outputs can be tied to what software asked
  always_ff @(posedge i_ref_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      {wa, wd, code_sh, mask_sh} <= '0;
      func_sh <= prc_pkg::PUMPFN_RST;
    end
    else
    begin
      if (taken)
        wa <= s_axi_awaddr[5:2];
      if (s_axi_wvalid && s_axi_wready)
        wd <= s_axi_wdata[7:0];
      if (commit && wa == prc_pkg::IDX_PUMPFN)
        func_sh <= wd;
      if (commit && wa == prc_pkg::IDX_PUMP)
        code_sh <= wd;
      if (commit && wa == prc_pkg::IDX_STATMSK)
        mask_sh <= wd;
    end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  // Comparator paths are synchronised, so allow a few cycles of settling
  sequence hi_clamp_s;
    (func_sh[prc_pkg::PF_CHI] && i_cmp_high && settled) [*6];
  endsequence
  sequence lo_clamp_s;
    (func_sh[prc_pkg::PF_CLO] && i_cmp_low && settled) [*6];
  endsequence
  sequence held_s;
    (func_sh[3:1] == 3'b001 && settled) [*3];
  endsequence

  code_clip_a: assert property (settled |-> o_pump_current_code == code_exp)
    else $error("pump current code differs from programmed value");
  midrail_copy_a: assert property (settled |-> o_pump_midrail_bias == func_sh[4])
    else $error("midrail bias output differs from control");
  hold_reset_a: assert property (held_s |-> !o_pump_up && !o_pump_down)
    else $error("pump pulse while detector held in reset");
  force_source_a: assert property ((func_sh == 8'h0a && settled) [*2] |-> o_pump_up)
    else $error("forced source current missing");
  upper_clamp_a: assert property (hi_clamp_s |-> !o_pump_up)
    else $error("sourcing while upper clamp active");
  lower_clamp_a: assert property (lo_clamp_s |-> !o_pump_down)
    else $error("sinking while lower clamp active");
  stat_masked_a: assert property ((mask_sh == 8'h00 && settled) [*2] |-> !o_stat)
    else $error("status pin high with all flags masked");
  stat_amp_a: assert property ((mask_sh == 8'h04 && i_amp_high && settled) [*6] |-> o_stat)
    else $error("status pin low with amplitude flag selected");
endmodule : prc_chk

bind prc_top prc_chk u_chk (.*);

//--- bench/tb.sv
`timescale 1ns/10ps
module tb;
  logic        i_ref_clk, i_rst_b, i_ref_in, i_fb_div, i_cmp_high, i_cmp_low, i_amp_high;
  logic        i_amp_low, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, o_stat;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, o_ref_div, o_pump_up, o_pump_down, o_pump_midrail_bias;
  logic        o_pump_pulse_extend, o_ref_out_powerdown, o_ref_gain_boost;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb, o_pump_current_code;
  logic [1:0]  s_axi_bresp, s_axi_rresp, o_ref_lowpass_select, rs, q;
  logic [7:0]  ra [9] = '{8'h28, 8'h0c, 8'h10, 8'h00, 8'h08, 8'h1c, 8'h20, 8'h24, 8'h2c};
  logic [7:0]  rv [9] = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  fnv [6] = '{8'h02, 8'h00, 8'h20, 8'h0a, 8'h06, 8'h01};
  logic [1:0]  dirv [6] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h2};
  int          rdiv [3] = '{5, 1023, 1};
  int          miscompares, checks_done, cycles, lag, n_up, n_dn, p;

  prc_top u_dut (.*);

  initial
  begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  // Reference of 8 clocks; feedback is the same wave delayed by lag clocks
  always @(posedge i_ref_clk)
  begin
    cycles <= cycles + 1;
    i_ref_in <= cycles[2];
    i_fb_div <= ((cycles - lag) & 4) != 0;
    if (cycles == 90000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp

  // Address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d,
                           input logic [1:0] er = prc_pkg::RESP_OKAY);
    @(posedge i_ref_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk_resp("write resp", er, s_axi_bresp);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge i_ref_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge i_ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : axi_read

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    axi_read(a);
    chk_word("register read", {24'h0, exp}, rd);
    chk_resp("read resp", prc_pkg::RESP_OKAY, rs);
  endtask : rchk

  // Rising-edge spacing of the divided reference, after one settling period
  task automatic period();
    @(posedge o_ref_div);
    @(posedge o_ref_div);
    #1 p = cycles;
    @(posedge o_ref_div);
    #1 p = cycles - p;
  endtask : period

  // Cycles of source only and sink only over a fixed span
  task automatic pulses();
    {n_up, n_dn} = '0;
    repeat (8) @(posedge i_ref_clk);
    repeat (64)
    begin
      @(posedge i_ref_clk);
      n_up += (o_pump_up === 1'b1 && o_pump_down === 1'b0);
      n_dn += (o_pump_down === 1'b1 && o_pump_up === 1'b0);
    end
  endtask : pulses

  task automatic clamp_step(input logic [7:0] f, input logic [1:0] hl, input logic [7:0] st,
                            input logic [1:0] dirs);
    {i_cmp_high, i_cmp_low} <= hl;
    axi_write(8'h28, f);
    pulses();
    chk_word("clamp pulses", dirs, {n_up > 0, n_dn > 0});
    rchk(8'h00, st);
    chk_word("status pin", st[4], o_stat);
  endtask : clamp_step

  initial
  begin
    {i_rst_b, i_ref_in, i_fb_div, i_cmp_high, i_cmp_low, i_amp_high, i_amp_low} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hf;
    {miscompares, checks_done, cycles} = '0;
    lag = 1;
    repeat (20) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    for (int i = 0; i < 9; i++)
      rchk(ra[i], rv[i]);
    axi_write(8'h14, 8'hff, prc_pkg::RESP_SLVERR);
    axi_read(8'h14);
    chk_word("unmapped data", 32'h0, rd);
    chk_resp("unmapped resp", prc_pkg::RESP_SLVERR, rs);
    $display("test reset_values done");
    foreach (rdiv[i])
    begin
      axi_write(8'h0c, 8'(rdiv[i] >> 8));
      axi_write(8'h10, 8'(rdiv[i]));
      rchk(8'h0c, 8'(rdiv[i] >> 8));
      period();
      chk_word("divided period", rdiv[i] * 8, p);
    end
    $display("test divider done");
    for (int c = 0; c < 16; c++)
    begin
      axi_write(8'h24, 8'(c));
      repeat (3) @(posedge i_ref_clk);
      chk_word("pump code", (c > 11) ? 11 : c, o_pump_current_code);
    end
    for (int i = 0; i < 4; i++)
    begin
      q = 2'(i);
      // Lowpass codes 0, 1 and 3 only; code 2 has no use
      axi_write(8'h20, {5'h0, q[0], q[1], q[1] | q[0]});
      axi_write(8'h08, {6'h0, q[0], 1'b0});
      axi_write(8'h28, {3'h0, q[0], 2'h0, 1'b1, q[0]});
      repeat (3) @(posedge i_ref_clk);
      chk_word("control copies", {q[1], q[1] | q[0], {4{q[0]}}},
               {o_ref_lowpass_select, o_ref_gain_boost,
               o_ref_out_powerdown, o_pump_pulse_extend, o_pump_midrail_bias});
    end
    $display("test controls done");
    lag = 3;
    foreach (fnv[i])
    begin
      axi_write(8'h28, fnv[i]);
      pulses();
      chk_word("pulse sense", dirv[i], {n_up > 0, n_dn > 0});
    end
    axi_write(8'h2c, 8'h10);
    clamp_step(8'h80, 2'b10, 8'h10, 2'h0);
    clamp_step(8'h60, 2'b01, 8'h20, 2'h0);
    clamp_step(8'h20, 2'b01, 8'h00, 2'h1);
    axi_write(8'h2c, 8'h04);
    i_amp_high <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
    rchk(8'h00, 8'h04);
    chk_word("status pin", 32'h1, o_stat);
    i_amp_high <= 1'b0;
    axi_write(8'h2c, 8'h00);
    $display("test pump done");
    lag = 1;
    axi_write(8'h28, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      axi_write(8'h24, 8'(16 * i + 5));
      axi_write(8'h1c, 8'(16 + i));
      repeat (192 << (2 * i)) @(posedge i_ref_clk);
      rchk(8'h00, 8'h00);
      repeat (128 << (2 * i)) @(posedge i_ref_clk);
      rchk(8'h00, 8'h02);
      lag = 4;
      repeat (24) @(posedge i_ref_clk);
      rchk(8'h00, 8'h01);
      lag = 1;
      repeat (24) @(posedge i_ref_clk);
      rchk(8'h00, 8'h00);
      lag = 4;
      axi_write(8'h1c, 8'h00);
      repeat (24) @(posedge i_ref_clk);
      rchk(8'h00, 8'h00);
      lag = 1;
    end
    $display("test lock done");
    print_verdict();
  end
endmodule : tb
